// [dv/bpcs_far_model.sv]
// far side cluster controllers answering or ignoring terminal side polls
`timescale 1ns/1ps
`default_nettype none
module bpcs_far_model (
  input  wire logic       mclk,
  input  wire logic       poll,
  input  wire logic [3:0] mute,
  output logic [3:0]      poll_noresp,
  output logic [3:0]      poll_resp
);
  // quiet lines until the first poll so no unknown reaches the design
  initial
  begin
    poll_noresp = 4'h0;
    poll_resp   = 4'h0;
  end

  // one verdict per poll: a muted controller stays silent, others answer
  always @(posedge mclk)
  begin
    poll_noresp <= poll ? mute : 4'h0;
    poll_resp   <= poll ? ~mute : 4'h0;
  end
endmodule : bpcs_far_model
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench of the call admission supervisor
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end
module testbench;
  int          mismatches = 0;
  int          checked    = 0;
  logic        mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        call_req = 1'b0, call_has_cu = 1'b0, call_has_dev = 1'b0, diag_req = 1'b0;
  logic        poll = 1'b0, pready, pslverr, call_done, call_accept, diag_valid, irq, er;
  logic [7:0]  paddr = 8'h00, call_app = 8'h02, call_cu = 8'h00, call_dev = 8'h00;
  logic [7:0]  caller_cu = 8'h00, caller_dev = 8'h00, diag_cu, diag_dev;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [1:0]  call_mode = 2'b00;
  logic [5:0]  call_params = 6'h00;
  logic [3:0]  diag_slot = 4'h0, mute = 4'h0, host_poll = 4'h0;
  logic [3:0]  poll_noresp, poll_resp, call_slot, slow_poll, cu_retired;
  logic [15:0] data_act = 16'h0000, net_clear = 16'h0000, logged_on = 16'h0000;
  logic [15:0] call_clear, ir_status;

  // short tick keeps every timer small
  bpcs_top #(.TICK_CYC(4)) u_bpcs_top (
    .mclk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .call_req, .call_mode, .call_app, .call_has_cu, .call_cu, .call_has_dev, .call_dev,
    .call_params, .caller_cu, .caller_dev, .call_done, .call_accept, .call_slot,
    .data_act, .net_clear, .logged_on, .host_poll, .poll_noresp, .poll_resp, .diag_req,
    .diag_slot, .diag_valid, .diag_cu, .diag_dev, .call_clear, .ir_status, .slow_poll,
    .cu_retired, .irq);
  bpcs_far_model u_bpcs_far_model (.mclk, .poll, .mute, .poll_noresp, .poll_resp);

  // 20 mhz clock
  initial
  begin
    forever #25 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb transfer; idle edge after release so back to back calls never collide
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    psel    <= 1'b1;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  // one call request, judged in its done cycle
  task automatic call(input logic [1:0] m, input logic [7:0] cu, dv, input logic [5:0] p,
                      input logic acc, input logic [3:0] slot);
    call_req    <= 1'b1;
    call_mode   <= m;
    call_cu     <= cu;
    call_dev    <= dv;
    call_params <= p;
    @(posedge mclk);
    call_req    <= 1'b0;
    @(posedge mclk);
    `CHK("done", 1'b1, call_done)
    `CHK("accept", acc, call_accept)
    if (acc)
      `CHK("slot", slot, call_slot)
  endtask : call

  // one poll round of the far side, then let the verdict settle
  task automatic poll_once(input logic [3:0] m);
    mute <= m;
    poll <= 1'b1;
    @(posedge mclk);
    poll <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : poll_once

  ////////////////////////////////////////////////////////////////////////////////
  // controller c at c0+c, devices 40..43, params 05 on low half, 0a on high
  task automatic t_setup;
    apb(1'b1, bpcs_pkg::OFS_CTRL, 32'h0000_0000);
    apb(1'b1, bpcs_pkg::OFS_LINE_APP, 32'h0000_0002);
    for (int i = 0; i < 16; i++)
    begin
      apb(1'b1, bpcs_pkg::OFS_TBL_IDX, i);
      apb(1'b1, bpcs_pkg::OFS_TBL_DATA, {17'h0, 1'b1, (i < 8) ? 6'h05 : 6'h0A, 6'h10, i[1:0]});
      apb(1'b1, bpcs_pkg::OFS_CU_ADDR, {24'h0, 6'h30, i[1:0]});
    end
    apb(1'b0, 8'h30, 32'h0000_0000);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0000_0000, rd)
  endtask : t_setup

  // destination matched searches, busy skipping and diagnostic
  task automatic t_match;
    call(2'b11, 8'h00, 8'h00, 6'h0A, 1'b1, 4'h8);
    call(2'b11, 8'h00, 8'h00, 6'h0A, 1'b1, 4'h9);
    call_has_cu <= 1'b1;
    call(2'b11, 8'hC3, 8'h00, 6'h0A, 1'b1, 4'hC);
    call_has_cu  <= 1'b0;
    call_has_dev <= 1'b1;
    call(2'b11, 8'h00, 8'h43, 6'h05, 1'b1, 4'h3);
    call(2'b11, 8'h00, 8'h43, 6'h3F, 1'b0, 4'h0);
    call(2'b00, 8'h00, 8'h42, 6'h05, 1'b0, 4'h0);
    diag_slot <= 4'hC;
    diag_req  <= 1'b1;
    @(posedge mclk);
    diag_req  <= 1'b0;
    @(posedge mclk);
    `CHK("diag valid", 1'b1, diag_valid)
    `CHK("diag cu", 8'hC3, diag_cu)
    `CHK("diag dev", 8'h40, diag_dev)
  endtask : t_match

  // fixed address and source chosen modes
  task automatic t_fixed;
    call_has_cu <= 1'b1;
    caller_cu   <= 8'hC0;
    caller_dev  <= 8'h40;
    call(2'b01, 8'hC1, 8'h41, 6'h05, 1'b0, 4'h0);
    caller_cu   <= 8'hC1;
    caller_dev  <= 8'h41;
    call(2'b01, 8'hC1, 8'h41, 6'h05, 1'b1, 4'h5);
    call(2'b10, 8'hC1, 8'h42, 6'h05, 1'b1, 4'h6);
    call(2'b10, 8'hC1, 8'h43, 6'h0A, 1'b0, 4'h0);
  endtask : t_fixed

  // controller 1 falls silent, is retired, then answers again
  task automatic t_super;
    poll_once(4'h2);
    `CHK("slow", 4'h2, slow_poll)
    `CHK("retired early", 4'h0, cu_retired)
    poll_once(4'h2);
    poll_once(4'h2);
    `CHK("retired", 4'h2, cu_retired)
    apb(1'b0, bpcs_pkg::OFS_STATE, 32'h0000_0000);
    `CHK("state", 32'h1308_0022, rd)
    call_has_dev <= 1'b0;
    call(2'b11, 8'hC1, 8'h00, 6'h05, 1'b0, 4'h0);
    poll_once(4'h0);
    `CHK("restored", 4'h0, cu_retired)
    `CHK("slow off", 4'h0, slow_poll)
    call(2'b11, 8'hC1, 8'h00, 6'h05, 1'b1, 4'h4);
  endtask : t_super

  // sticky status, masking and clearing of the interrupt
  task automatic t_irq;
    apb(1'b0, bpcs_pkg::OFS_STAT, 32'h0000_0000);
    `CHK("stat", 32'h0000_001B, rd)
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, bpcs_pkg::OFS_INT_EN, 32'h0000_0010);
    @(posedge mclk);
    `CHK("irq up", 1'b1, irq)
    apb(1'b1, bpcs_pkg::OFS_INT_CLR, 32'h0000_0010);
    @(posedge mclk);
    `CHK("irq down", 1'b0, irq)
    apb(1'b0, bpcs_pkg::OFS_STAT, 32'h0000_0000);
    `CHK("stat left", 32'h0000_000B, rd)
  endtask : t_irq

  // slot 12 goes quiet while every other slot keeps its traffic
  task automatic t_idle;
    int n;
    logged_on <= 16'hFFFF;
    data_act  <= 16'hEFFF;
    apb(1'b1, bpcs_pkg::OFS_INACT, 32'h0000_0002);
    apb(1'b1, bpcs_pkg::OFS_CTRL, 32'h0000_0001);
    for (n = 0; n < 100 && call_clear === 16'h0000; n++)
      @(posedge mclk);
    `CHK("idle clear", 16'h1000, call_clear)
    `CHK("ir terminal", 16'h0000, ir_status)
    data_act <= 16'h0000;
  endtask : t_idle

  // host stops polling controller 0, then polls it again
  task automatic t_host;
    int n;
    host_poll <= 4'hE;
    apb(1'b1, bpcs_pkg::OFS_CTRL, 32'h0000_0002);
    for (n = 0; n < 2000 && call_clear === 16'h0000; n++)
      @(posedge mclk);
    `CHK("retire clear", 16'h0008, call_clear)
    `CHK("ir host", 16'h0008, ir_status)
    `CHK("host retired", 4'h1, cu_retired)
    call(2'b11, 8'hC0, 8'h00, 6'h05, 1'b0, 4'h0);
    host_poll <= 4'hF;
    @(posedge mclk);
    call(2'b11, 8'hC0, 8'h00, 6'h05, 1'b1, 4'h0);
  endtask : t_host

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    if (mismatches == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  // reset for six cycles, then the scenarios in order
  initial
  begin
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    t_setup;
    t_match;
    t_fixed;
    t_super;
    t_irq;
    t_idle;
    t_host;
    final_report;
  end

  // hang guard: the sequence needs about fifteen hundred cycles
  initial
  begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    final_report;
  end
endmodule : testbench
`default_nettype wire

// [src/bpcs_cu_sup.sv]
// polling supervision of one cluster controller, host or terminal role
`timescale 1ns/1ps
`default_nettype none
module bpcs_cu_sup (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic host_side,
  input  wire logic tick,
  input  wire logic host_poll,
  input  wire logic poll_noresp,
  input  wire logic poll_resp,
  output logic      retired,
  output logic      slow,
  output logic      retire_p,
  output logic      restore_p
);
  typedef struct packed {
    bpcs_pkg::bpcs_cu_t st;
    logic [1:0]         miss;
    logic [8:0]         secs;
    logic               retire_p;
    logic               restore_p;
  } bpcs_sup_t;
  bpcs_sup_t s_q;
  bpcs_sup_t s_d;

  ////////////////////////////////////////////////////////////////////////
  // next state; a poll or answer in the retire cycle wins and keeps the controller active
  always_comb
  begin
    s_d           = s_q;
    s_d.retire_p  = 1'b0;
    s_d.restore_p = 1'b0;
    if (host_side)
    begin
      if (host_poll)
      begin
        s_d.secs = 9'h000;
        if (s_q.st == bpcs_pkg::CU_RETIRED)
          s_d.restore_p = 1'b1;
        s_d.st = bpcs_pkg::CU_ACTIVE;
      end
      else if (tick && s_q.st != bpcs_pkg::CU_RETIRED)
      begin
        if (s_q.secs == 9'(bpcs_pkg::HOST_POLL_TICKS - 1))
        begin
          s_d.st       = bpcs_pkg::CU_RETIRED;
          s_d.retire_p = 1'b1;
        end
        else
          s_d.secs = s_q.secs + 9'h001;
      end
    end
    else if (poll_resp)
    begin
      if (s_q.st == bpcs_pkg::CU_RETIRED)
        s_d.restore_p = 1'b1;
      s_d.st   = bpcs_pkg::CU_ACTIVE;
      s_d.miss = 2'h0;
    end
    else if (poll_noresp)
    begin
      unique case (s_q.st)
        bpcs_pkg::CU_ACTIVE:
        begin
          s_d.st   = bpcs_pkg::CU_SLOW;
          s_d.miss = 2'h0;
        end
        bpcs_pkg::CU_SLOW:
        begin
          if (s_q.miss == 2'(bpcs_pkg::SLOW_MISSES - 1))
          begin
            s_d.st       = bpcs_pkg::CU_RETIRED;
            s_d.retire_p = 1'b1;
          end
          else
            s_d.miss = s_q.miss + 2'h1;
        end
        default: s_d.st = bpcs_pkg::CU_RETIRED;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // retired controllers keep slow polling on the terminal side
  assign retired   = s_q.st == bpcs_pkg::CU_RETIRED;
  assign slow      = ~host_side & (s_q.st != bpcs_pkg::CU_ACTIVE);
  assign retire_p  = s_q.retire_p;
  assign restore_p = s_q.restore_p;

  slow_retire_a: assert property (@(posedge mclk) disable iff (!nrst)
    (!host_side && s_q.st == bpcs_pkg::CU_SLOW && s_q.miss == 2'h1 && poll_noresp
     && !poll_resp) |=> retire_p && retired)
    else $error("third missed poll did not retire controller");
  host_restore_a: assert property (@(posedge mclk) disable iff (!nrst)
    (host_side && host_poll && retired) |=> restore_p && !retired)
    else $error("host poll did not restore controller");
endmodule : bpcs_cu_sup
`default_nettype wire

// [src/bpcs_match.sv]
// first available matching device search over the device table
`timescale 1ns/1ps
`default_nettype none
module bpcs_match (
  input  wire logic [1:0]  mode,
  input  wire logic        app_ok,
  input  wire logic        has_cu,
  input  wire logic [7:0]  req_cu,
  input  wire logic        has_dev,
  input  wire logic [7:0]  req_dev,
  input  wire logic [5:0]  req_par,
  input  wire logic [7:0]  own_cu,
  input  wire logic [7:0]  own_dev,
  input  wire logic [15:0] valid,
  input  wire logic [15:0] busy,
  input  wire logic [3:0]  retired,
  input  wire logic [95:0] par,
  input  wire logic [127:0] device_address,
  input  wire logic [31:0] controller_address,
  output logic             hit,
  output logic [3:0]       slot
);
  logic [15:0] ok;

  ////////////////////////////////////////////////////////////////////////
  // per-slot qualification; slot order gives controller-major first fit
  for (genvar i = 0; i < bpcs_pkg::N_SLOT; i++)
  begin : g_slot
    logic cu_eq;
    logic dv_eq;
    logic p_eq;
    logic sel;
    assign cu_eq = req_cu == controller_address[(i/bpcs_pkg::N_DEV)*8 +: 8];
    assign dv_eq = req_dev == device_address[i*8 +: 8];
    assign p_eq  = req_par == par[i*6 +: 6];
    always_comb
    begin
      unique case (bpcs_bpcs_mode(mode))
        bpcs_pkg::MODE_FIXED_ADDRESS:
          sel = has_cu & has_dev & cu_eq & dv_eq
              & (req_cu == own_cu) & (req_dev == own_dev);
        bpcs_pkg::MODE_SOURCE_CHOSEN:
          sel = has_cu & has_dev & cu_eq & dv_eq;
        bpcs_pkg::MODE_DEST_MATCHED:
          sel = (~has_cu | cu_eq) & (~has_dev | dv_eq);
        default:
          sel = 1'b0;
      endcase
    end
    // retired controllers take no new calls
    assign ok[i] = sel & p_eq & app_ok & valid[i] & ~busy[i]
                 & ~retired[i/bpcs_pkg::N_DEV];
  end

  function automatic bpcs_pkg::bpcs_mode_t bpcs_bpcs_mode(input logic [1:0] m);
    return bpcs_pkg::bpcs_mode_t'(m);
  endfunction : bpcs_bpcs_mode

  ////////////////////////////////////////////////////////////////////////
  // priority pick of the lowest qualifying slot
  always_comb
  begin
    hit  = 1'b0;
    slot = 4'h0;
    for (int i = bpcs_pkg::N_SLOT - 1; i >= 0; i--)
    begin
      if (ok[i])
      begin
        hit  = 1'b1;
        slot = 4'(i);
      end
    end
  end
endmodule : bpcs_match
`default_nettype wire

// [src/bpcs_pkg.sv]
// constants, register map and enumerations of the call admission supervisor
package bpcs_pkg;
  localparam int N_CU   = 4;
  localparam int N_DEV  = 4;
  localparam int N_SLOT = N_CU * N_DEV;
  // timing
  localparam int CLK_HZ          = 20_000_000;
  localparam int TICK_S          = 1;
  localparam int TICK_CYC_DEF    = CLK_HZ * TICK_S;
  localparam int HOST_POLL_TMO_S = 300;
  localparam int HOST_POLL_TICKS = HOST_POLL_TMO_S / TICK_S;
  localparam int SLOW_MISSES     = 2;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_LINE_APP = 8'h04;
  localparam logic [7:0] OFS_INACT    = 8'h08;
  localparam logic [7:0] OFS_TBL_IDX  = 8'h0C;
  localparam logic [7:0] OFS_TBL_DATA = 8'h10;
  localparam logic [7:0] OFS_CU_ADDR  = 8'h14;
  localparam logic [7:0] OFS_STATE    = 8'h18;
  localparam logic [7:0] OFS_STAT     = 8'h1C;
  localparam logic [7:0] OFS_INT_EN   = 8'h20;
  localparam logic [7:0] OFS_INT_CLR  = 8'h24;
  // field positions
  localparam int CTRL_INACT_EN = 0;
  localparam int CTRL_HOST     = 1;
  localparam int TBL_VALID     = 14;
  localparam int TBL_PAR_LSB   = 8;
  localparam int STATE_BUSY    = 16;
  localparam int STATE_SLOW    = 4;
  // status bits
  localparam int ST_ACCEPT  = 0;
  localparam int ST_REFUSE  = 1;
  localparam int ST_INACT   = 2;
  localparam int ST_RETIRE  = 3;
  localparam int ST_RESTORE = 4;
  localparam int N_ST       = 5;
  // values after reset
  localparam logic [7:0]  INACT_RST = 8'h00;
  localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_NONE           = 2'b00,
    MODE_FIXED_ADDRESS  = 2'b01,
    MODE_SOURCE_CHOSEN  = 2'b10,
    MODE_DEST_MATCHED   = 2'b11
  } bpcs_mode_t;

  typedef enum logic [1:0] {
    CU_ACTIVE  = 2'b00,
    CU_SLOW    = 2'b01,
    CU_RETIRED = 2'b10
  } bpcs_cu_t;
endpackage : bpcs_pkg

// [src/bpcs_top.sv]
// call admission and supervision core with apb registers
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - fixed address mode reaches one destination and exactly one device per call
// - fixed address mode demands requested controller and device equal caller's own
// - source chosen mode takes caller's controller and device; parameters must agree
// - destination matched mode compares type, colour, format and character set
// - accept only with an available fully matching device, otherwise refuse
// - application id only: first available match on the bound line
// - with a controller named: first available match on that controller
// - with a device address only: scan all controllers for that address
// - enabled inactivity timer clears an idle call after the set period
// - host side retires a controller unpolled five minutes, clears and refuses
// - host polling a retired controller again restores it
// - terminal side enters slow poll when a controller misses a poll
// - two more misses clear calls, refuse calls, keep slow polling
// - an answer to slow poll makes the controller accept calls again
// - diagnostic tells which host side device a call is connected to
// - call cleared while logged on reports intervention required to host, on the host side only
module bpcs_top #(
  parameter int TICK_CYC = bpcs_pkg::TICK_CYC_DEF
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        call_req,
  input  wire logic [1:0]  call_mode,
  input  wire logic [7:0]  call_app,
  input  wire logic        call_has_cu,
  input  wire logic [7:0]  call_cu,
  input  wire logic        call_has_dev,
  input  wire logic [7:0]  call_dev,
  input  wire logic [5:0]  call_params,
  input  wire logic [7:0]  caller_cu,
  input  wire logic [7:0]  caller_dev,
  output logic             call_done,
  output logic             call_accept,
  output logic [3:0]       call_slot,
  input  wire logic [15:0] data_act,
  input  wire logic [15:0] net_clear,
  input  wire logic [15:0] logged_on,
  input  wire logic [3:0]  host_poll,
  input  wire logic [3:0]  poll_noresp,
  input  wire logic [3:0]  poll_resp,
  input  wire logic        diag_req,
  input  wire logic [3:0]  diag_slot,
  output logic             diag_valid,
  output logic [7:0]       diag_cu,
  output logic [7:0]       diag_dev,
  output logic [15:0]      call_clear,
  output logic [15:0]      ir_status,
  output logic [3:0]       slow_poll,
  output logic [3:0]       cu_retired,
  output logic             irq
);
  typedef struct packed {
    logic                 pready;
    logic                 pslverr;
    logic [31:0]          prdata;
    logic                 inact_en;
    logic                 host_side;
    logic [7:0]           line_app;
    logic [7:0]           inact_secs;
    logic [3:0]           tbl_idx;
    logic [15:0]          valid;
    logic [15:0][5:0]     par;
    logic [15:0][7:0]     device_address;
    logic [3:0][7:0]      controller_address;
    logic [15:0]          busy;
    logic [15:0][7:0]     idle;
    logic [31:0]          tick_cnt;
    logic                 tick;
    logic                 call_done;
    logic                 call_accept;
    logic [3:0]           call_slot;
    logic                 diag_valid;
    logic [7:0]           diag_cu;
    logic [7:0]           diag_dev;
    logic [15:0]          call_clear;
    logic [15:0]          ir_status;
    logic [4:0]           stat;
    logic [4:0]           int_en;
    logic                 irq;
  } bpcs_state_t;
  bpcs_state_t s_q;
  bpcs_state_t s_d;

  logic        hit;
  logic [3:0]  hit_slot;
  logic [3:0]  retired;
  logic [3:0]  slow;
  logic [3:0]  retire_p;
  logic [3:0]  restore_p;

  ////////////////////////////////////////////////////////////////////////
  // device search and per-controller supervisors
  bpcs_match u_match (
    .mode    (call_mode),
    .app_ok  (call_app == s_q.line_app),
    .has_cu  (call_has_cu),
    .req_cu  (call_cu),
    .has_dev (call_has_dev),
    .req_dev (call_dev),
    .req_par (call_params),
    .own_cu  (caller_cu),
    .own_dev (caller_dev),
    .valid   (s_q.valid),
    .busy    (s_q.busy),
    .retired (retired),
    .par     (s_q.par),
    .device_address     (s_q.device_address),
    .controller_address     (s_q.controller_address),
    .hit     (hit),
    .slot    (hit_slot)
  );

  for (genvar c = 0; c < bpcs_pkg::N_CU; c++)
  begin : g_cu
    bpcs_cu_sup u_sup (
      .mclk        (mclk),
      .nrst        (nrst),
      .host_side   (s_q.host_side),
      .tick        (s_q.tick),
      .host_poll   (host_poll[c]),
      .poll_noresp (poll_noresp[c]),
      .poll_resp   (poll_resp[c]),
      .retired     (retired[c]),
      .slow        (slow[c]),
      .retire_p    (retire_p[c]),
      .restore_p   (restore_p[c])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    logic        acc;
    logic        wr;
    logic [15:0] clr;
    logic [15:0] tmo;
    logic [4:0]  ev;
    logic [4:0]  wclr;
    s_d            = s_q;
    acc            = psel & penable & ~s_q.pready;
    wr             = psel & penable & s_q.pready & pwrite;
    clr            = 16'h0000;
    tmo            = 16'h0000;
    ev             = 5'h00;
    wclr           = 5'h00;
    s_d.call_done  = 1'b0;
    s_d.diag_valid = 1'b0;
    // one second enable; long count stays a parameter for short sims
    s_d.tick = s_q.tick_cnt == 32'(TICK_CYC - 1);
    s_d.tick_cnt = s_d.tick ? 32'h0000_0000 : s_q.tick_cnt + 32'h0000_0001;

    // apb: one wait state, pready registered
    s_d.pready  = acc;
    s_d.pslverr = 1'b0;
    if (acc)
    begin
      s_d.prdata = bpcs_pkg::RD_ZERO;
      unique case (paddr)
        bpcs_pkg::OFS_CTRL:
          s_d.prdata[1:0] = {s_q.host_side, s_q.inact_en};
        bpcs_pkg::OFS_LINE_APP: s_d.prdata[7:0] = s_q.line_app;
        bpcs_pkg::OFS_INACT:    s_d.prdata[7:0] = s_q.inact_secs;
        bpcs_pkg::OFS_TBL_IDX:  s_d.prdata[3:0] = s_q.tbl_idx;
        bpcs_pkg::OFS_TBL_DATA:
          s_d.prdata[14:0] = {s_q.valid[s_q.tbl_idx], s_q.par[s_q.tbl_idx],
                              s_q.device_address[s_q.tbl_idx]};
        bpcs_pkg::OFS_CU_ADDR:  s_d.prdata[7:0] = s_q.controller_address[s_q.tbl_idx[1:0]];
        bpcs_pkg::OFS_STATE:
          s_d.prdata = {s_q.busy, 8'h00, slow, retired};
        bpcs_pkg::OFS_STAT:     s_d.prdata[4:0] = s_q.stat;
        bpcs_pkg::OFS_INT_EN:   s_d.prdata[4:0] = s_q.int_en;
        bpcs_pkg::OFS_INT_CLR:  s_d.prdata      = bpcs_pkg::RD_ZERO;
        default:                s_d.pslverr     = 1'b1;
      endcase
    end
    // writes land on the completing edge only
    if (wr)
    begin
      unique case (paddr)
        bpcs_pkg::OFS_CTRL:
        begin
          s_d.inact_en  = pwdata[bpcs_pkg::CTRL_INACT_EN];
          s_d.host_side = pwdata[bpcs_pkg::CTRL_HOST];
        end
        bpcs_pkg::OFS_LINE_APP: s_d.line_app   = pwdata[7:0];
        bpcs_pkg::OFS_INACT:    s_d.inact_secs = pwdata[7:0];
        bpcs_pkg::OFS_TBL_IDX:  s_d.tbl_idx    = pwdata[3:0];
        bpcs_pkg::OFS_TBL_DATA:
        begin
          s_d.valid[s_q.tbl_idx] = pwdata[bpcs_pkg::TBL_VALID];
          s_d.par[s_q.tbl_idx]   = pwdata[bpcs_pkg::TBL_PAR_LSB +: 6];
          s_d.device_address[s_q.tbl_idx]   = pwdata[7:0];
        end
        bpcs_pkg::OFS_CU_ADDR:  s_d.controller_address[s_q.tbl_idx[1:0]] = pwdata[7:0];
        bpcs_pkg::OFS_INT_EN:   s_d.int_en = pwdata[4:0];
        bpcs_pkg::OFS_INT_CLR:  wclr       = pwdata[4:0];
        default: ;
      endcase
    end

    // inactivity timers; traffic either way restarts, free slots stay at zero
    for (int i = 0; i < bpcs_pkg::N_SLOT; i++)
    begin
      if (!s_q.busy[i] || data_act[i])
        s_d.idle[i] = 8'h00;
      else if (s_q.tick && s_q.inact_en)
        s_d.idle[i] = s_q.idle[i] + 8'h01;
      tmo[i] = s_q.busy[i] & s_q.inact_en & ~data_act[i]
             & (s_q.inact_secs != 8'h00)
             & (s_q.idle[i] >= s_q.inact_secs);
      if (retire_p[i/bpcs_pkg::N_DEV])
        clr[i] = 1'b1;
    end
    clr = (clr | tmo | net_clear) & s_q.busy;
    s_d.busy       = s_q.busy & ~clr;
    s_d.call_clear = clr;
    // lost session reported to the host only on the host side
    s_d.ir_status  = clr & logged_on & {16{s_q.host_side}};

    // admission; a slot cleared this cycle is not reusable until next
    if (call_req)
    begin
      s_d.call_done   = 1'b1;
      s_d.call_accept = hit;
      s_d.call_slot   = hit_slot;
      if (hit)
      begin
        s_d.busy[hit_slot] = 1'b1;
        s_d.idle[hit_slot] = 8'h00;
      end
    end

    // connection diagnostic
    if (diag_req)
    begin
      s_d.diag_valid = 1'b1;
      s_d.diag_cu    = s_q.busy[diag_slot] ? s_q.controller_address[diag_slot[3:2]] : 8'h00;
      s_d.diag_dev   = s_q.busy[diag_slot] ? s_q.device_address[diag_slot] : 8'h00;
    end

    // sticky status: setting wins over a clear in the same cycle
    ev[bpcs_pkg::ST_ACCEPT]  = call_req & hit;
    ev[bpcs_pkg::ST_REFUSE]  = call_req & ~hit;
    ev[bpcs_pkg::ST_INACT]   = |tmo;
    ev[bpcs_pkg::ST_RETIRE]  = |retire_p;
    ev[bpcs_pkg::ST_RESTORE] = |restore_p;
    s_d.stat = (s_q.stat & ~wclr) | ev;
    s_d.irq  = |(s_d.stat & s_d.int_en);
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata      = s_q.prdata;
  assign pready      = s_q.pready;
  assign pslverr     = s_q.pslverr;
  assign call_done   = s_q.call_done;
  assign call_accept = s_q.call_accept;
  assign call_slot   = s_q.call_slot;
  assign diag_valid  = s_q.diag_valid;
  assign diag_cu     = s_q.diag_cu;
  assign diag_dev    = s_q.diag_dev;
  assign call_clear  = s_q.call_clear;
  assign ir_status   = s_q.ir_status;
  assign slow_poll   = slow;
  assign cu_retired  = retired;
  assign irq         = s_q.irq;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence apb_acc_s;
    psel && penable && !pready;
  endsequence
  apb_wait_a: assert property (@(posedge mclk) disable iff (!nrst)
    apb_acc_s |=> pready ##1 !pready)
    else $error("apb answer not after exactly one wait state");
  call_answer_a: assert property (@(posedge mclk) disable iff (!nrst)
    call_req |=> call_done && (call_accept == $past(hit)))
    else $error("call request not answered next cycle");
  accept_busy_a: assert property (@(posedge mclk) disable iff (!nrst)
    call_done && call_accept |-> s_q.busy[call_slot])
    else $error("accepted slot not marked busy");
  refuse_retired_a: assert property (@(posedge mclk) disable iff (!nrst)
    call_done && call_accept |-> !$past(retired[hit_slot[3:2]]))
    else $error("call accepted for a retired controller");
  fixed_own_a: assert property (@(posedge mclk) disable iff (!nrst)
    call_req && call_mode == 2'b01 && call_cu != caller_cu |=> !call_accept)
    else $error("fixed mode accepted a foreign controller");
  ir_cause_a: assert property (@(posedge mclk) disable iff (!nrst)
    ir_status != 16'h0000 |-> (ir_status & ~call_clear) == 16'h0000
      && $past(s_q.host_side))
    else $error("intervention status without a cleared call");
  inact_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
    s_q.busy[0] && s_q.inact_en && s_q.inact_secs != 8'h00 && !data_act[0]
      && s_q.idle[0] >= s_q.inact_secs |=> call_clear[0] && !s_q.busy[0])
    else $error("idle call not cleared");
  act_restart_a: assert property (@(posedge mclk) disable iff (!nrst)
    s_q.busy[0] && data_act[0] |=> s_q.idle[0] == 8'h00)
    else $error("data activity did not restart timer");
  irq_level_a: assert property (@(posedge mclk) disable iff (!nrst)
    irq == |(s_q.stat & s_q.int_en))
    else $error("interrupt does not follow enabled status");
  diag_answer_a: assert property (@(posedge mclk) disable iff (!nrst)
    diag_req && s_q.busy[diag_slot] |=> diag_valid
      && diag_dev == $past(s_q.device_address[diag_slot]))
    else $error("diagnostic did not report the connected device");
endmodule : bpcs_top
`default_nettype wire
